// File: tmw_timer.sv
// Eight-bit timer with normal, clear-on-match and fast PWM waveform modes.
// Assumes a classic Wishbone master on clk_i and interrupt acknowledge
// strobes from an interrupt controller on the same clock.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tmw_timer #(
   parameter int ADR_W = 5
) (
   input wire logic clk_i,                 // 250 MHz system clock
   input wire logic rst_i,                 // Synchronous reset, high
   input wire logic cyc_i,                 // Wishbone cycle
   input wire logic stb_i,                 // Wishbone strobe
   input wire logic we_i,                  // Wishbone write enable
   input wire logic [ADR_W-1:0] adr_i,     // Wishbone byte address
   input wire logic [3:0] sel_i,           // Wishbone byte selects
   input wire logic [31:0] dat_i,          // Wishbone write data
   output logic [31:0] dat_o,              // Wishbone read data
   output logic ack_o,                     // Wishbone acknowledge
   input wire logic wrap_ack_i,            // Overflow interrupt serviced
   input wire logic match_ack_i,           // Match interrupt serviced
   output logic wrap_flag_o,               // Overflow flag
   output logic match_flag_o,              // Compare match flag
   output logic pin_out_o,                 // Port pin level
   output logic pin_oe_o                   // Port pin drive enable
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic apply_action(input tmw_pkg::tmw_action_type act,
                                         input logic cur);
      logic res;
      res = cur;
      unique case (act)
         tmw_pkg::ACT_NONE: res = cur;
         tmw_pkg::ACT_TOGGLE: res = ~cur;
         tmw_pkg::ACT_CLEAR: res = 1'b0;
         tmw_pkg::ACT_SET: res = 1'b1;
      endcase
      return res;
   endfunction : apply_action

   function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                    input logic [4:0] ofs);
      return adr == ADR_W'(ofs);
   endfunction : reg_hit

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   tmw_pkg::tmw_ctrl_type ctrl;
   logic [7:0] count_value;
   logic [7:0] compare_buf;
   logic [7:0] compare_value;
   logic wrap_flag;
   logic match_flag;
   logic wave_output;
   logic pin_dir;
   logic pin_data;
   logic match_block;
   logic [tmw_pkg::PRESCALE_BITS-1:0] prescale;
   logic ack;
   logic [31:0] rd_data;

   logic bus_req;
   logic wr_en;
   logic wr_ctrl;
   logic wr_count;
   logic wr_compare;
   logic wr_status;
   logic wr_pin;
   logic force_match_strobe;
   logic tick;
   logic pwm_mode;
   logic clear_on_match_mode;
   logic fast_pwm;
   logic at_max;
   logic at_top;
   logic match;
   logic [7:0] next_count;
   logic next_wave;
   logic [31:0] next_rd_data;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign bus_req = cyc_i & stb_i;
   // Writes take effect at the edge where ack is high
   assign wr_en = bus_req & we_i & ack & sel_i[0];
   assign wr_ctrl = wr_en & reg_hit(adr_i, tmw_pkg::CTRL_OFS);
   assign wr_count = wr_en & reg_hit(adr_i, tmw_pkg::COUNT_OFS);
   assign wr_compare = wr_en & reg_hit(adr_i, tmw_pkg::COMPARE_OFS);
   assign wr_status = wr_en & reg_hit(adr_i, tmw_pkg::STATUS_OFS);
   assign wr_pin = wr_en & reg_hit(adr_i, tmw_pkg::PIN_OFS);
   assign force_match_strobe = wr_ctrl & dat_i[tmw_pkg::CTRL_FORCE_BIT];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= bus_req & ~ack;
      end
   end

   always_comb
   begin
      next_rd_data = 32'h0000_0000;
      if (reg_hit(adr_i, tmw_pkg::CTRL_OFS))
      begin
         next_rd_data[6:0] = ctrl;
      end
      else if (reg_hit(adr_i, tmw_pkg::COUNT_OFS))
      begin
         next_rd_data[7:0] = count_value;
      end
      else if (reg_hit(adr_i, tmw_pkg::COMPARE_OFS))
      begin
         next_rd_data[7:0] = compare_buf;
      end
      else if (reg_hit(adr_i, tmw_pkg::STATUS_OFS))
      begin
         next_rd_data[tmw_pkg::STATUS_WRAP_BIT] = wrap_flag;
         next_rd_data[tmw_pkg::STATUS_MATCH_BIT] = match_flag;
      end
      else if (reg_hit(adr_i, tmw_pkg::PIN_OFS))
      begin
         next_rd_data[tmw_pkg::PIN_DIR_BIT] = pin_dir;
         next_rd_data[tmw_pkg::PIN_DATA_BIT] = pin_data;
         next_rd_data[tmw_pkg::PIN_WAVE_BIT] = wave_output;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_data <= 32'h0000_0000;
      end
      else if (bus_req & ~ack & ~we_i)
      begin
         rd_data <= next_rd_data;
      end
   end

   // ----------------------------------------------------------------
   // Control and pin registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl <= tmw_pkg::tmw_ctrl_type'(tmw_pkg::CTRL_RST[6:0]);
      end
      else if (wr_ctrl)
      begin
         ctrl <= tmw_pkg::tmw_ctrl_type'(dat_i[6:0]);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_dir <= tmw_pkg::PIN_RST[tmw_pkg::PIN_DIR_BIT];
         pin_data <= tmw_pkg::PIN_RST[tmw_pkg::PIN_DATA_BIT];
      end
      else if (wr_pin)
      begin
         pin_dir <= dat_i[tmw_pkg::PIN_DIR_BIT];
         pin_data <= dat_i[tmw_pkg::PIN_DATA_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prescale <= '0;
      end
      else
      begin
         prescale <= prescale + 1'b1;
      end
   end

   always_comb
   begin
      unique case (ctrl.clk_sel)
         tmw_pkg::CS_DIV1: tick = 1'b1;
         tmw_pkg::CS_DIV8: tick = &prescale[2:0];
         tmw_pkg::CS_DIV64: tick = &prescale[5:0];
         tmw_pkg::CS_DIV256: tick = &prescale[7:0];
         tmw_pkg::CS_DIV1024: tick = &prescale[9:0];
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Mode decode and compare
   // ----------------------------------------------------------------
   assign pwm_mode = ctrl.wave_mode_select[0];
   assign clear_on_match_mode = ctrl.wave_mode_select == tmw_pkg::MODE_CLEAR_ON_MATCH;
   assign fast_pwm = ctrl.wave_mode_select == tmw_pkg::MODE_FAST_PWM;
   assign at_max = count_value == tmw_pkg::COUNT_MAX;
   // Top is the compare value only in clear-on-match mode
   assign at_top = clear_on_match_mode ? (count_value == compare_value) : at_max;
   assign match = tick & ~match_block & (count_value == compare_value);

   // A count write blocks matches until one tick has passed
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         match_block <= 1'b0;
      end
      else if (wr_count)
      begin
         match_block <= 1'b1;
      end
      else if (tick)
      begin
         match_block <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_comb
   begin
      next_count = count_value + 8'h01;
      if (clear_on_match_mode & at_top & ~match_block)
      begin
         next_count = tmw_pkg::COUNT_BOTTOM;
      end
      else if (fast_pwm & at_max)
      begin
         next_count = tmw_pkg::COUNT_BOTTOM;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_value <= tmw_pkg::COUNT_RST;
      end
      else if (wr_count)
      begin
         count_value <= dat_i[7:0];
      end
      else if (tick)
      begin
         count_value <= next_count;
      end
   end

   // ----------------------------------------------------------------
   // Compare value and its buffer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         compare_buf <= tmw_pkg::COMPARE_RST;
      end
      else if (wr_compare)
      begin
         compare_buf <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         compare_value <= tmw_pkg::COMPARE_RST;
      end
      else if (~pwm_mode)
      begin
         compare_value <= wr_compare ? dat_i[7:0] : compare_buf;
      end
      else if (tick & at_max & ~wr_count)
      begin
         compare_value <= compare_buf;
      end
   end

   // ----------------------------------------------------------------
   // Flags: hardware set wins over any clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wrap_flag <= 1'b0;
      end
      else if (tick & ~wr_count & at_max)
      begin
         wrap_flag <= 1'b1;
      end
      else if (wrap_ack_i)
      begin
         wrap_flag <= 1'b0;
      end
      else if (wr_status & dat_i[tmw_pkg::STATUS_WRAP_BIT])
      begin
         wrap_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         match_flag <= 1'b0;
      end
      else if (match)
      begin
         match_flag <= 1'b1;
      end
      else if (match_ack_i | (wr_status & dat_i[tmw_pkg::STATUS_MATCH_BIT]))
      begin
         match_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Waveform generator
   // ----------------------------------------------------------------
   always_comb
   begin
      next_wave = wave_output;
      if (fast_pwm)
      begin
         // Bottom update wins, so compare at max holds a constant level
         if (tick & at_max & ~wr_count)
         begin
            if (ctrl.output_action_select == tmw_pkg::ACT_CLEAR)
            begin
               next_wave = 1'b1;
            end
            else if (ctrl.output_action_select == tmw_pkg::ACT_SET)
            begin
               next_wave = 1'b0;
            end
         end
         else if (match & ctrl.output_action_select[1])
         begin
            next_wave = apply_action(ctrl.output_action_select, wave_output);
         end
      end
      else if (~pwm_mode)
      begin
         if (force_match_strobe)
         begin
            next_wave = apply_action(tmw_pkg::tmw_action_type'(dat_i[3:2]),
                                     wave_output);
         end
         else if (match)
         begin
            next_wave = apply_action(ctrl.output_action_select, wave_output);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wave_output <= 1'b0;
      end
      else
      begin
         wave_output <= next_wave;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_out_o <= 1'b0;
         pin_oe_o <= 1'b0;
      end
      else
      begin
         // Override port data whenever an action is selected
         pin_out_o <= (ctrl.output_action_select != tmw_pkg::ACT_NONE) ?
                      next_wave : pin_data;
         pin_oe_o <= pin_dir;
      end
   end

   assign dat_o = rd_data;
   assign ack_o = ack;
   assign wrap_flag_o = wrap_flag;
   assign match_flag_o = match_flag;

endmodule : tmw_timer

`default_nettype wire

// File: tmw_pkg.sv
// Constants and types for the eight-bit waveform timer.
// Assumes a 32-bit classic Wishbone register bus; all registers fit in the low 8 bits.
package tmw_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] COUNT_OFS = 5'h04;
   localparam logic [4:0] COMPARE_OFS = 5'h08;
   localparam logic [4:0] STATUS_OFS = 5'h0c;
   localparam logic [4:0] PIN_OFS = 5'h10;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_FORCE_BIT = 7;
   localparam int STATUS_WRAP_BIT = 0;
   localparam int STATUS_MATCH_BIT = 1;
   localparam int PIN_DIR_BIT = 0;
   localparam int PIN_DATA_BIT = 1;
   localparam int PIN_WAVE_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COMPARE_RST = 8'h00;
   localparam logic [7:0] PIN_RST = 8'h00;

   // ----------------------------------------------------------------
   // Counting constants
   // ----------------------------------------------------------------
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam int PRESCALE_BITS = 10;

   // ----------------------------------------------------------------
   // Modes and actions
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_PHASE_PWM = 2'h1,
      MODE_CLEAR_ON_MATCH = 2'h2,
      MODE_FAST_PWM = 2'h3
   } tmw_mode_type;

   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_CLEAR = 2'h2,
      ACT_SET = 2'h3
   } tmw_action_type;

   // Clock select: 0 stops the timer
   typedef enum logic [2:0] {
      CS_STOP = 3'h0,
      CS_DIV1 = 3'h1,
      CS_DIV8 = 3'h2,
      CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4,
      CS_DIV1024 = 3'h5
   } tmw_clk_sel_type;

   // Control register layout, bits 6:0 (bit 7 is the force strobe)
   typedef struct packed {
      tmw_clk_sel_type clk_sel;
      tmw_action_type output_action_select;
      tmw_mode_type wave_mode_select;
   } tmw_ctrl_type;

endpackage : tmw_pkg

// File: tmw_timer_assertions.sv
// Port checker for the eight-bit waveform timer.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tmw_chk #(
   parameter int ADR_W = 5
) (
   input wire logic clk_i,             // Clock
   input wire logic rst_i,             // Reset
   input wire logic cyc_i,             // Bus cycle
   input wire logic stb_i,             // Bus strobe
   input wire logic we_i,              // Bus write
   input wire logic [ADR_W-1:0] adr_i, // Bus address
   input wire logic [3:0] sel_i,       // Byte selects
   input wire logic [31:0] dat_i,      // Write data
   input wire logic [31:0] dat_o,      // Read data
   input wire logic ack_o,             // Acknowledge
   input wire logic wrap_ack_i,        // Wrap service
   input wire logic match_ack_i,       // Match service
   input wire logic wrap_flag_o,       // Wrap flag
   input wire logic match_flag_o,      // Match flag
   input wire logic pin_out_o,         // Pin level
   input wire logic pin_oe_o           // Pin enable
);
   // ----------------------------------------------------------------
   // Causes of flag and pin changes
   // ----------------------------------------------------------------
   logic wr_ok;
   logic st_wr;
   logic pin_wr;
   assign wr_ok = ack_o & cyc_i & stb_i & we_i & sel_i[0];
   assign st_wr = wr_ok & (adr_i == tmw_pkg::STATUS_OFS);
   assign pin_wr = wr_ok & (adr_i == tmw_pkg::PIN_OFS);

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ACK_ONE:
      assert property (cyc_i & stb_i & !ack_o |=> ack_o) else $error("ack late");
   AST_ACK_PULSE:
      assert property (ack_o |=> !ack_o) else $error("ack held");
   AST_RD_UPPER:
      assert property (ack_o & !we_i |-> dat_o[31:8] == 24'h000000) else $error("upper bits");
   AST_RD_UNMAP:
      assert property (ack_o & !we_i & (adr_i > 5'h10) |-> dat_o == 32'h0) else $error("unmapped");
   AST_RD_STATUS:
      assert property (ack_o & !we_i & (adr_i == tmw_pkg::STATUS_OFS)
         |-> dat_o[1:0] == {$past(match_flag_o), $past(wrap_flag_o)}) else $error("status read");
   AST_WRAP_HOLD:
      assert property ($fell(wrap_flag_o)
         |-> $past(rst_i | wrap_ack_i | (st_wr & dat_i[0]))) else $error("wrap lost");
   AST_MATCH_HOLD:
      assert property ($fell(match_flag_o)
         |-> $past(rst_i | match_ack_i | (st_wr & dat_i[1]))) else $error("match lost");
   AST_PIN_OE:
      assert property ($changed(pin_oe_o)
         |-> $past(pin_wr | rst_i) || $past(pin_wr, 2)) else $error("enable moved");

   cover property (ack_o & we_i);
   cover property ($rose(wrap_flag_o));
   cover property ($rose(match_flag_o));
   cover property ($changed(pin_out_o));
endmodule : tmw_chk

bind tmw_timer tmw_chk #(.ADR_W(ADR_W)) tmw_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .wrap_ack_i(wrap_ack_i), .match_ack_i(match_ack_i),
   .wrap_flag_o(wrap_flag_o), .match_flag_o(match_flag_o), .pin_out_o(pin_out_o),
   .pin_oe_o(pin_oe_o));
`default_nettype wire

// File: tmw_timer_tb.sv
// Self-checking bench for the eight-bit waveform timer.
// Assumes the register map of tmw_pkg and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tmw_timer_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd, a, hi;
   logic ack_o, wrap_ack_i = 1'b0, match_ack_i = 1'b0, k;
   logic wrap_flag_o, match_flag_o, pin_out_o, pin_oe_o;
   logic [7:0] top, cv;
   logic [1:0] act;
   int n_errors = 0, n_checks = 0, cycles = 0, c;
   int f [6] = '{1, 1, 8, 64, 256, 1024};

   tmw_timer #(.ADR_W(5)) tmw_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .wrap_ack_i(wrap_ack_i), .match_ack_i(match_ack_i),
      .wrap_flag_o(wrap_flag_o), .match_flag_o(match_flag_o), .pin_out_o(pin_out_o),
      .pin_oe_o(pin_oe_o));

   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Tasks and expectations
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= ad;
      sel_i <= 4'h1;
      dat_i <= {24'h000000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : bus

   function automatic logic [31:0] pwm_hi(input logic [7:0] v, input logic [1:0] m);
      pwm_hi = (m == 2'h2) ? 32'(2 * (v + 1)) : 32'(512 - 2 * (v + 1));
   endfunction : pwm_hi

   function automatic logic [31:0] ctc_next(input logic [31:0] v, input logic [7:0] t);
      ctc_next = (v + 3) % (32'(t) + 1);
   endfunction : ctc_next

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         $display("[FAIL] %0t timeout", $time);
         n_errors++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(89));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b1, 5'h14, 8'hff);
         bus(1'b0, 5'(4 * i), 8'h00);
         chk(rd, 32'h0);
      end
      chk(32'(pin_oe_o), 32'h0);
      $display("reset test done");
      bus(1'b1, tmw_pkg::PIN_OFS, 8'h03);
      repeat (3) @(posedge clk_i);
      chk(32'(pin_oe_o), 32'h1);
      chk(32'(pin_out_o), 32'h1);
      bus(1'b1, tmw_pkg::PIN_OFS, 8'h01);
      repeat (3) @(posedge clk_i);
      chk(32'(pin_out_o), 32'h0);
      for (int i = 3; i > 0; i--)
      begin
         bus(1'b1, tmw_pkg::CTRL_OFS, 8'(8'h80 | (i << 2)));
         repeat (3) @(posedge clk_i);
         chk(32'(pin_out_o), 32'(i != 2));
      end
      chk(32'(match_flag_o), 32'h0);
      bus(1'b0, tmw_pkg::CTRL_OFS, 8'h00);
      chk(rd, 32'h04);
      $display("pin and force test done");
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h00);
      bus(1'b1, tmw_pkg::COMPARE_OFS, 8'h20);
      bus(1'b1, tmw_pkg::COUNT_OFS, 8'h20);
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h10);
      repeat (20) @(posedge clk_i);
      chk(32'(match_flag_o), 32'h0);
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h00);
      bus(1'b1, tmw_pkg::COUNT_OFS, 8'h1e);
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h10);
      repeat (20) @(posedge clk_i);
      chk(32'(match_flag_o), 32'h1);
      match_ack_i <= 1'b1;
      @(posedge clk_i);
      match_ack_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(match_flag_o), 32'h0);
      $display("match block test done");
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, tmw_pkg::COUNT_OFS, 8'(8'hf8 + $urandom % 8));
         bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
         a = rd;
         bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
         chk(rd, (a + 3) & 32'hff);
      end
      // Stop the timer so no wrap can land on the service pulse
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h00);
      chk(32'(wrap_flag_o), 32'h1);
      wrap_ack_i <= 1'b1;
      @(posedge clk_i);
      wrap_ack_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(wrap_flag_o), 32'h0);
      bus(1'b1, tmw_pkg::COUNT_OFS, 8'hfe);
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h10);
      repeat (6) @(posedge clk_i);
      chk(32'(wrap_flag_o), 32'h1);
      $display("normal test done");
      for (int s = 2; s < 6; s++)
      begin
         bus(1'b1, tmw_pkg::CTRL_OFS, 8'(s << 4));
         bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
         a = rd;
         repeat (1021) @(posedge clk_i);
         bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
         chk((rd - a) & 32'hff, 32'((1024 / f[s]) & 255));
      end
      $display("prescaler test done");
      top = 8'(2 + $urandom % 8);
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h00);
      bus(1'b1, tmw_pkg::COUNT_OFS, 8'h00);
      bus(1'b1, tmw_pkg::COMPARE_OFS, top);
      bus(1'b1, tmw_pkg::STATUS_OFS, 8'h03);
      bus(1'b1, tmw_pkg::CTRL_OFS, 8'h16);
      repeat (20) @(posedge clk_i);
      chk(32'(match_flag_o), 32'h1);
      chk(32'(wrap_flag_o), 32'h0);
      bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
      a = rd;
      bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
      chk(rd, ctc_next(a, top));
      k = pin_out_o;
      while (pin_out_o === k)
         @(posedge clk_i);
      k = pin_out_o;
      c = 0;
      while (pin_out_o === k && c < 300)
      begin
         @(posedge clk_i);
         c++;
      end
      chk(32'(c), 32'(top) + 32'h1);
      bus(1'b1, tmw_pkg::COUNT_OFS, 8'h80);
      bus(1'b1, tmw_pkg::STATUS_OFS, 8'h03);
      repeat (40) @(posedge clk_i);
      chk(32'(match_flag_o), 32'h0);
      bus(1'b0, tmw_pkg::COUNT_OFS, 8'h00);
      chk(32'(rd > 32'h80), 32'h1);
      repeat (200) @(posedge clk_i);
      chk(32'(wrap_flag_o), 32'h1);
      chk(32'(match_flag_o), 32'h1);
      $display("clear on match test done");
      for (int j = 0; j < 6; j++)
      begin
         cv = (j < 2) ? 8'h00 : (j < 4) ? 8'hff : 8'($urandom);
         act = 2'(2 + j % 2);
         bus(1'b1, tmw_pkg::CTRL_OFS, {4'h1, act, 2'h3});
         bus(1'b1, tmw_pkg::COMPARE_OFS, cv);
         bus(1'b1, tmw_pkg::STATUS_OFS, 8'h03);
         repeat (300) @(posedge clk_i);
         chk(32'(wrap_flag_o), 32'h1);
         bus(1'b0, tmw_pkg::COMPARE_OFS, 8'h00);
         chk(rd, 32'(cv));
         hi = 0;
         repeat (512)
         begin
            @(posedge clk_i);
            hi += 32'(pin_out_o === 1'b1);
         end
         chk(hi, pwm_hi(cv, act));
      end
      $display("fast pwm test done");
      close_out();
   end
endmodule : tmw_timer_tb
`default_nettype wire
